// *** design/gcid_gpio_top.v ***
// gpio pin controller: change interrupt, alternate select, parallel detect
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "gcid_map.vh"
module gcid_gpio_top #(
	parameter NUM_PINS  = 64,
	parameter NUM_SD    = 16,
	parameter NUM_PORTS = 32,
	parameter SD_PIN_LO = 44,
	parameter SD_FUNC   = 2
) (
	// clock and reset
	input  wire                 ref_clk,
	input  wire                 rst,
	// ahb-lite slave
	input  wire                 hsel,
	input  wire [11:0]          haddr,
	input  wire [1:0]           htrans,
	input  wire                 hwrite,
	input  wire [2:0]           hsize,
	input  wire [31:0]          hwdata,
	input  wire                 hready,
	output reg  [31:0]          hrdata,
	output reg                  hreadyout,
	output reg                  hresp,
	// pins
	input  wire [NUM_PINS-1:0]  pin_in,
	output reg  [NUM_PINS-1:0]  pin_out,
	output reg  [NUM_PINS-1:0]  pin_oe,
	// alternate function select, per pin
	output reg  [NUM_PINS-1:0]  alt_sel0,
	output reg  [NUM_PINS-1:0]  alt_sel1,
	// serial controller detect values and merged result
	input  wire [NUM_PORTS-1:0] serial_sd,
	output reg  [NUM_PORTS-1:0] port_sd,
	// interrupt to processor
	output reg                  pin_irq
);
	localparam HALF = 32;

	// register state; each 64-bit group is a low and high word
	reg  [NUM_PINS-1:0]          out_reg;
	reg  [NUM_PINS-1:0]          oe_reg;
	reg  [NUM_PINS-1:0]          alt0_reg;
	reg  [NUM_PINS-1:0]          alt1_reg;
	reg  [NUM_PINS-1:0]          ena_reg;
	reg  [NUM_SD*`GCID_PORT_IDX_W-1:0] map_reg;
	reg  [NUM_PINS-1:0]          clr_next;

	// data-phase capture
	reg                          wr_pend_reg;
	reg                          rd_wait_reg;
	reg  [11:0]                  addr_reg;

	wire [NUM_PINS-1:0]          level;
	wire [NUM_PINS-1:0]          flags;
	wire [NUM_PINS-1:0]          active;
	wire [NUM_SD-1:0]            sd_en;
	wire [NUM_SD-1:0]            sd_in;
	wire [NUM_PORTS-1:0]         merged;
	wire                         take;
	wire                         hi_word;
	wire [11:0]                  word_addr;
	wire [`GCID_MAP_IDX_W-1:0]   map_idx;
	wire                         is_map;
	reg  [31:0]                  rd_next;

	// one write strobe per writable register, decoded in the data phase
	wire                         wr_out;
	wire                         wr_set;
	wire                         wr_clr;
	wire                         wr_oe;
	wire                         wr_alt0;
	wire                         wr_alt1;
	wire                         wr_flags;
	wire                         wr_ena;
	wire                         wr_map;

	assign take      = hsel & hready & htrans[1];
	assign hi_word   = addr_reg[`GCID_HI_WORD_BIT];
	assign word_addr = addr_reg & ~(12'h001 << `GCID_HI_WORD_BIT);
	assign map_idx   = addr_reg[`GCID_MAP_IDX_LSB +: `GCID_MAP_IDX_W];
	assign is_map    = (addr_reg >= `GCID_OFS_MAP_BASE) && (addr_reg <= `GCID_OFS_MAP_LAST);

	// selects the low or high word of a 64-bit pin vector
	function [31:0] half_sel;
		input [63:0] v;
		input        hi;
		begin
			half_sel = hi ? v[2*HALF-1:HALF] : v[HALF-1:0];
		end
	endfunction

	// writes one word of a 64-bit pin vector
	function [63:0] half_put;
		input [63:0] v;
		input        hi;
		input [31:0] d;
		begin
			half_put = hi ? {d, v[HALF-1:0]} : {v[2*HALF-1:HALF], d};
		end
	endfunction

	// data-phase write hit on one register word
	function wr_hit;
		input        pend;
		input [11:0] a;
		input [11:0] ofs;
		begin
			wr_hit = pend & (a == ofs);
		end
	endfunction

	assign active = flags & ena_reg;

	// map words never alias a plain register word
	assign wr_out   = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_OUT);
	assign wr_set   = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_OUT_SET);
	assign wr_clr   = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_OUT_CLR);
	assign wr_oe    = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_OE);
	assign wr_alt0  = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_ALT0);
	assign wr_alt1  = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_ALT1);
	assign wr_flags = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_FLAGS);
	assign wr_ena   = wr_hit(wr_pend_reg, word_addr, `GCID_OFS_ENABLE);
	assign wr_map   = wr_pend_reg & is_map;

	// parallel detect n sits on a pin in function two
	genvar g;
	generate
		for (g = 0; g < NUM_SD; g = g + 1) begin : g_sd
			assign sd_en[g] = ({alt1_reg[SD_PIN_LO+g], alt0_reg[SD_PIN_LO+g]}
				== SD_FUNC[1:0]);
			assign sd_in[g] = level[SD_PIN_LO+g];
		end
	endgenerate

	gcid_change_det #(
		.WIDTH     (NUM_PINS)
	) u_det (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pin_in    (pin_in),
		.clear_mask(clr_next),
		.level_reg (level),
		.flags_reg (flags)
	);

	gcid_sd_override #(
		.NUM_SD               (NUM_SD),
		.NUM_PORTS            (NUM_PORTS),
		.IDX_W                (`GCID_PORT_IDX_W)
	) u_sd (
		.detect_port_index    (map_reg),
		.sd_enable            (sd_en),
		.parallel_detect_input(sd_in),
		.serial_sd            (serial_sd),
		.merged_sd            (merged)
	);

	// write-one-to-clear of change flags, applied in the data phase
	always @* begin
		clr_next = {NUM_PINS{1'b0}};
		if (wr_flags) begin
			clr_next = half_put({NUM_PINS{1'b0}}, hi_word, hwdata);
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		rd_next = `GCID_RST_WORD;
		if (is_map) begin
			rd_next = {{(32-`GCID_PORT_IDX_W){1'b0}},
				map_reg[map_idx*`GCID_PORT_IDX_W +: `GCID_PORT_IDX_W]};
		end else begin
			case (word_addr)
			`GCID_OFS_OUT:      rd_next = half_sel(out_reg, hi_word);
			`GCID_OFS_IN:       rd_next = half_sel(level, hi_word);
			`GCID_OFS_OE:       rd_next = half_sel(oe_reg, hi_word);
			`GCID_OFS_ALT0:     rd_next = half_sel(alt0_reg, hi_word);
			`GCID_OFS_ALT1:     rd_next = half_sel(alt1_reg, hi_word);
			`GCID_OFS_FLAGS:    rd_next = half_sel(flags, hi_word);
			`GCID_OFS_ENABLE:   rd_next = half_sel(ena_reg, hi_word);
			`GCID_OFS_ACTIVE:   rd_next = half_sel(active, hi_word);
			`GCID_OFS_SD_VALUE: rd_next = hi_word ? `GCID_RST_WORD : merged;
			default:            rd_next = `GCID_RST_WORD;
			endcase
		end
	end

	// bus slave: writes take no wait state; a read waits one cycle so that
	// hrdata comes from a flip-flop yet still sees a write just before it
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			addr_reg    <= 12'h000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= `GCID_RST_WORD;
		end else begin
			hresp <= 1'b0;
			if (rd_wait_reg) begin
				// load the word and release the master on the same edge
				rd_wait_reg <= 1'b0;
				hreadyout   <= 1'b1;
				hrdata      <= rd_next;
			end else if (hready) begin
				wr_pend_reg <= take & hwrite;
				rd_wait_reg <= take & ~hwrite;
				hreadyout   <= ~(take & ~hwrite);
				if (take) begin
					addr_reg <= haddr;
				end
			end
		end
	end

	// output value; set and clear words let threads update without locks
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_reg <= {NUM_PINS{1'b0}};
		end else if (wr_out) begin
			out_reg <= half_put(out_reg, hi_word, hwdata);
		end else if (wr_set) begin
			out_reg <= out_reg | half_put({NUM_PINS{1'b0}}, hi_word, hwdata);
		end else if (wr_clr) begin
			out_reg <= out_reg & ~half_put({NUM_PINS{1'b0}}, hi_word, hwdata);
		end
	end

	// pins stay inputs until software sets their enable
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oe_reg <= {NUM_PINS{1'b0}};
		end else if (wr_oe) begin
			oe_reg <= half_put(oe_reg, hi_word, hwdata);
		end
	end

	// low bit of the alternate code
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alt0_reg <= {NUM_PINS{1'b0}};
		end else if (wr_alt0) begin
			alt0_reg <= half_put(alt0_reg, hi_word, hwdata);
		end
	end

	// high bit of the alternate code
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alt1_reg <= {NUM_PINS{1'b0}};
		end else if (wr_alt1) begin
			alt1_reg <= half_put(alt1_reg, hi_word, hwdata);
		end
	end

	// change interrupt enables
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ena_reg <= {NUM_PINS{1'b0}};
		end else if (wr_ena) begin
			ena_reg <= half_put(ena_reg, hi_word, hwdata);
		end
	end

	// index before enabling the function avoids a spurious override
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			map_reg <= {NUM_SD{`GCID_RST_PORT}};
		end else if (wr_map) begin
			map_reg[map_idx*`GCID_PORT_IDX_W +: `GCID_PORT_IDX_W]
				<= hwdata[`GCID_PORT_IDX_W-1:0];
		end
	end

	// registered pin and select outputs
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_out  <= {NUM_PINS{1'b0}};
			pin_oe   <= {NUM_PINS{1'b0}};
			alt_sel0 <= {NUM_PINS{1'b0}};
			alt_sel1 <= {NUM_PINS{1'b0}};
		end else begin
			pin_out  <= out_reg;
			pin_oe   <= oe_reg;
			alt_sel0 <= alt0_reg;
			alt_sel1 <= alt1_reg;
		end
	end

	// registered detect and interrupt outputs
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			port_sd <= {NUM_PORTS{1'b0}};
			pin_irq <= 1'b0;
		end else begin
			port_sd <= merged;
			pin_irq <= |active;
		end
	end
endmodule // gcid_gpio_top

// *** common/gcid_map.vh ***
// register map and field constants for the gpio change and detect block
`ifndef GCID_MAP_VH
`define GCID_MAP_VH

`define GCID_OFS_OUT        12'h000
`define GCID_OFS_OUT_SET    12'h004
`define GCID_OFS_OUT_CLR    12'h008
`define GCID_OFS_IN         12'h00c
`define GCID_OFS_OE         12'h010
`define GCID_OFS_ALT0       12'h014
`define GCID_OFS_ALT1       12'h018
`define GCID_OFS_FLAGS      12'h01c
`define GCID_OFS_ENABLE     12'h020
`define GCID_OFS_ACTIVE     12'h024
`define GCID_OFS_SD_VALUE   12'h028
`define GCID_OFS_MAP_BASE   12'h040
`define GCID_OFS_MAP_LAST   12'h07c

`define GCID_HI_WORD_BIT    7
`define GCID_MAP_IDX_LSB    2
`define GCID_MAP_IDX_W      4
`define GCID_PORT_IDX_W     5
`define GCID_ALT_GPIO       2'h0
`define GCID_ALT_FUNC1      2'h1
`define GCID_ALT_FUNC2      2'h2
`define GCID_HTRANS_NONSEQ  1'b1
`define GCID_RST_WORD       32'h00000000
`define GCID_RST_PORT       5'h00

`endif

// *** design/gcid_change_det.v ***
// per-pin input change detector with sticky write-one-to-clear flags
`timescale 1ns/1ps
module gcid_change_det #(
	parameter WIDTH = 32
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             rst,
	// pins
	input  wire [WIDTH-1:0] pin_in,
	// software clear
	input  wire [WIDTH-1:0] clear_mask,
	// results
	output reg  [WIDTH-1:0] level_reg,
	output reg  [WIDTH-1:0] flags_reg
);
	reg              primed_reg;
	wire [WIDTH-1:0] change;

	// no change is claimed until a first sample stands as reference
	assign change = primed_reg ? (pin_in ^ level_reg) : {WIDTH{1'b0}};

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			level_reg  <= {WIDTH{1'b0}};
			flags_reg  <= {WIDTH{1'b0}};
			primed_reg <= 1'b0;
		end else begin
			level_reg  <= pin_in;
			primed_reg <= 1'b1;
			flags_reg  <= (flags_reg & ~clear_mask) | change;
		end
	end
endmodule // gcid_change_det

// *** design/gcid_sd_override.v ***
// parallel detect override of the serial controller's per-port detect values
`timescale 1ns/1ps
module gcid_sd_override #(
	parameter NUM_SD = 16,
	parameter NUM_PORTS = 32,
	parameter IDX_W = 5
) (
	// map and enables
	input  wire [NUM_SD*IDX_W-1:0] detect_port_index,
	input  wire [NUM_SD-1:0]       sd_enable,
	input  wire [NUM_SD-1:0]       parallel_detect_input,
	// serial controller values in, merged values out
	input  wire [NUM_PORTS-1:0]    serial_sd,
	output reg  [NUM_PORTS-1:0]    merged_sd
);
	integer n;
	integer p;

	// later detect numbers win if two map to one port
	always @* begin
		merged_sd = serial_sd;
		for (p = 0; p < NUM_PORTS; p = p + 1) begin
			for (n = 0; n < NUM_SD; n = n + 1) begin
				if (sd_enable[n] && detect_port_index[n*IDX_W +: IDX_W] == p[IDX_W-1:0]) begin
					merged_sd[p] = parallel_detect_input[n];
				end
			end
		end
	end
endmodule // gcid_sd_override

// *** tb/gcid_gpio_assertions.sv ***
// concurrent checks on the pin controller's ports
`timescale 1ns/1ps
module gcid_gpio_assertions #(
	parameter NUM_PINS  = 64,
	parameter NUM_PORTS = 32
) (
	// clock and reset
	input wire                 ref_clk,
	input wire                 rst,
	// bus
	input wire                 hsel,
	input wire [11:0]          haddr,
	input wire [1:0]           htrans,
	input wire                 hwrite,
	input wire [31:0]          hwdata,
	input wire                 hready,
	input wire                 hreadyout,
	input wire                 hresp,
	// pins and detect
	input wire [NUM_PINS-1:0]  pin_in,
	input wire [NUM_PINS-1:0]  pin_out,
	input wire [NUM_PINS-1:0]  pin_oe,
	input wire [NUM_PINS-1:0]  alt_sel0,
	input wire [NUM_PINS-1:0]  alt_sel1,
	input wire [NUM_PORTS-1:0] serial_sd,
	input wire [NUM_PORTS-1:0] port_sd,
	input wire                 pin_irq
);
	wire wr = hsel && hready && htrans[1] && hwrite;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
	a_write_no_wait: assert property (wr |=> hreadyout) else $error("write stretched");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	a_out_follows_write: assert property (wr && haddr == 12'h000 ##1 1'b1
		|-> ##2 pin_out[31:0] == $past(hwdata, 2)) else $error("pin_out stale");
	a_oe_needs_write: assert property (!$stable(pin_oe)
		|-> $past(wr, 2) || $past(wr, 3)) else $error("pin_oe moved alone");
	a_alt_needs_write: assert property (!$stable({alt_sel1, alt_sel0})
		|-> $past(wr, 2) || $past(wr, 3)) else $error("alt select moved alone");
	a_irq_rise_cause: assert property ($rose(pin_irq)
		|-> $past(pin_in, 3) != $past(pin_in, 4) || $past(pin_in, 2) != $past(pin_in, 3)
		|| $past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("irq rose alone");
	a_irq_fall_cause: assert property ($fell(pin_irq)
		|-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("irq fell alone");
	a_sd_passthru: assert property (alt_sel1[59:44] == 16'h0 [*3]
		|-> port_sd == $past(serial_sd)) else $error("port_sd not serial");
endmodule // gcid_gpio_assertions

bind gcid_gpio_top gcid_gpio_assertions #(.NUM_PINS(NUM_PINS), .NUM_PORTS(NUM_PORTS)) chk_u (
	.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
	.pin_in, .pin_out, .pin_oe, .alt_sel0, .alt_sel1, .serial_sd, .port_sd, .pin_irq);

// *** tb/gcid_pin_model.sv ***
// pad model: each pin shows the controller's drive or the outside level
`timescale 1ns/1ps
module gcid_pin_model (
	// controller side
	input  wire [63:0] pin_out,
	input  wire [63:0] pin_oe,
	// outside world
	input  wire [63:0] ext_lvl,
	output wire [63:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gcid_pin_model

// *** tb/test_gcid_gpio_top.sv ***
// register-level tests of the pin controller
`timescale 1ns/1ps
`include "gcid_map.vh"
module test_gcid_gpio_top;
	logic        ref_clk = 0;
	logic        rst = 1;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic [11:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] rd;
	logic [31:0] serial_sd = 0;
	logic [63:0] ext_lvl = 0;
	wire  [31:0] hrdata, port_sd;
	wire         hreadyout, hresp, pin_irq;
	wire  [63:0] pin_in, pin_out, pin_oe, alt_sel0, alt_sel1;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;

	gcid_gpio_top dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .alt_sel0(alt_sel0), .alt_sel1(alt_sel1),
		.serial_sd(serial_sd), .port_sd(port_sd), .pin_irq(pin_irq));
	gcid_pin_model pad_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
		.pin_in(pin_in));

	initial forever #2 ref_clk = ~ref_clk;

	task print_verdict;
		$display("compared %0d, mismatched %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer; the slave may stretch either phase
	task xfer(input w, input [11:0] a, input [31:0] wd, output [31:0] d);
		@(posedge ref_clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		d = hrdata;
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			print_verdict;
		end
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 0;
		xfer(0, `GCID_OFS_OE, 0, rd); chk(rd, 0);
		xfer(0, `GCID_OFS_ALT1 + 12'h080, 0, rd); chk(rd, 0);
		xfer(1, `GCID_OFS_OE, 32'h000000ff, rd);
		xfer(1, `GCID_OFS_OUT, 32'h000000a5, rd);
		repeat (3) @(posedge ref_clk);
		chk(pin_oe[31:0], 32'h000000ff);
		chk(pin_out[31:0], 32'h000000a5);
		xfer(0, `GCID_OFS_IN, 0, rd); chk(rd, 32'h000000a5);
		$display("drive test done");
		xfer(1, `GCID_OFS_FLAGS, 32'hffffffff, rd);
		xfer(1, `GCID_OFS_ENABLE, 32'h00000100, rd);
		ext_lvl[9:8] <= 2'h3;
		repeat (4) @(posedge ref_clk);
		xfer(0, `GCID_OFS_FLAGS, 0, rd); chk(rd, 32'h00000300);
		xfer(0, `GCID_OFS_ACTIVE, 0, rd); chk(rd, 32'h00000100);
		chk({31'h0, pin_irq}, 1);
		xfer(1, `GCID_OFS_FLAGS, 32'h00000100, rd);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, pin_irq}, 0);
		xfer(0, `GCID_OFS_FLAGS, 0, rd); chk(rd, 32'h00000200);
		xfer(0, 12'h030, 0, rd); chk(rd, 0);
		// pin 8 changes in the very data phase that clears its flag
		fork
			xfer(1, `GCID_OFS_FLAGS, 32'h00000100, rd);
			begin
				repeat (2) @(posedge ref_clk);
				ext_lvl[8] <= 1'b0;
			end
		join
		repeat (3) @(posedge ref_clk);
		xfer(0, `GCID_OFS_FLAGS, 0, rd); chk(rd, 32'h00000300);
		chk({31'h0, pin_irq}, 1);
		$display("irq test done");
		// map before enabling the function, so no port sees a stale index
		serial_sd <= 32'h99996666;
		for (int n = 0; n < 16; n++) xfer(1, `GCID_OFS_MAP_BASE + 12'(4 * n), n, rd);
		xfer(1, `GCID_OFS_ALT1 + 12'h080, 32'h0ffff000, rd);
		ext_lvl[59:44] <= 16'h5a3c;
		repeat (4) @(posedge ref_clk);
		chk(alt_sel1[63:32], 32'h0ffff000);
		chk(port_sd, 32'h99995a3c);
		xfer(0, `GCID_OFS_SD_VALUE, 0, rd); chk(rd, 32'h99995a3c);
		// function one on the first four detect pins hands those ports back
		xfer(1, `GCID_OFS_ALT1 + 12'h080, 32'h0fff0000, rd);
		xfer(1, `GCID_OFS_ALT0 + 12'h080, 32'h0000f000, rd);
		repeat (3) @(posedge ref_clk);
		chk(alt_sel0[63:32], 32'h0000f000);
		chk(port_sd, 32'h99995a36);
		$display("detect test done");
		print_verdict;
	end
endmodule // test_gcid_gpio_top
